// file: hdl/nco_channel_select.sv
// Oscillator channel selection with APB register and pin edge counter.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module nco_channel_select
  import osc_sel_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset.
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Channel-select pins from the external controller.
  input  wire logic              select_pin_a_bit0,
  input  wire logic              select_pin_a_bit1,
  input  wire logic              select_pin_b_bit0,
  input  wire logic              select_pin_b_bit1,
  // Active oscillator channel.
  output logic      [3:0]        active_channel
);

  // The address must hold the register offset.
  if (ADDR_W < 12) begin : g_addr_chk
    $error("ADDR_W too small for the register map");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops per pin, first stage read only by second.
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic [3:0] pin_last_reg;
  logic [3:0] pin_raw;
  logic [3:0] pin_rise;

  assign pin_raw = {select_pin_b_bit1, select_pin_b_bit0,
                    select_pin_a_bit1, select_pin_a_bit0};

  // Synchroniser and edge history, one per pin.
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_pin
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_meta_reg[gi] <= 1'b0;
        pin_sync_reg[gi] <= 1'b0;
        pin_last_reg[gi] <= 1'b0;
      end else begin
        pin_meta_reg[gi] <= pin_raw[gi];
        pin_sync_reg[gi] <= pin_meta_reg[gi];
        pin_last_reg[gi] <= pin_sync_reg[gi];
      end
    end
    assign pin_rise[gi] = pin_sync_reg[gi] & ~pin_last_reg[gi];
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB register file: one control register, zero-wait answers.
  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [31:0] prdata_next;
  logic        pslverr_next;
  logic        pready_next;
  logic        setup;
  logic        hit;

  assign setup = psel && !penable;
  // Zero-extend the offset so a wider address bus decodes the same word.
  assign hit   = (paddr == ADDR_W'(CTRL_ADDR));

  // Decode in the setup cycle so the access phase completes at once.
  always_comb begin
    ctrl_next    = ctrl_reg;
    prdata_next  = prdata;
    pslverr_next = 1'b0;  // The error flag stands only beside pready.
    pready_next  = 1'b0;
    if (setup) begin
      pready_next  = 1'b1;
      pslverr_next = !hit;
      prdata_next  = 32'h0000_0000;
      if (hit && !pwrite) begin
        prdata_next = {24'h00_0000, ctrl_reg};
      end
    end else if (psel && penable && pready && pwrite && hit && pstrb[0]) begin
      ctrl_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
      pready   <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      prdata   <= prdata_next;
      pslverr  <= pslverr_next;
      pready   <= pready_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Edge counter and channel selection.
  logic [3:0] mode;
  logic [3:0] field;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] chan_next;
  logic       edge_hit;

  assign mode  = ctrl_reg[MODE_MSB:MODE_LSB];
  assign field = ctrl_reg[CHAN_MSB:CHAN_LSB];

  // Counter steps on the chosen pin edge and wraps to zero at the limit.
  // A limit of zero holds the counter at zero, which is the safe reading.
  always_comb begin
    edge_hit   = 1'b0;
    count_next = count_reg;
    case (mode)
      MODE_EDGE_A0: edge_hit = pin_rise[PIN_A0];
      MODE_EDGE_A1: edge_hit = pin_rise[PIN_A1];
      MODE_EDGE_B0: edge_hit = pin_rise[PIN_B0];
      MODE_EDGE_B1: edge_hit = pin_rise[PIN_B1];
      default:      edge_hit = 1'b0;
    endcase
    if (edge_hit) begin
      if (count_reg >= field) begin
        count_next = COUNT_RESET;
      end else begin
        count_next = count_reg + 4'h1;
      end
    end
  end

  // Channel index per select mode; unlisted codes fall back to the field.
  always_comb begin
    case (mode)
      MODE_B0A0:     chan_next = {2'b00, pin_sync_reg[PIN_B0],
                                  pin_sync_reg[PIN_A0]};
      MODE_B1A1:     chan_next = {2'b00, pin_sync_reg[PIN_B1],
                                  pin_sync_reg[PIN_A1]};
      MODE_A1A0:     chan_next = {2'b00, pin_sync_reg[PIN_A1],
                                  pin_sync_reg[PIN_A0]};
      MODE_B1B0:     chan_next = {2'b00, pin_sync_reg[PIN_B1],
                                  pin_sync_reg[PIN_B0]};
      MODE_B1A1B0A0: chan_next = {pin_sync_reg[PIN_B1], pin_sync_reg[PIN_A1],
                                  pin_sync_reg[PIN_B0],
                                  pin_sync_reg[PIN_A0]};
      MODE_B1B0A1A0: chan_next = pin_sync_reg;
      MODE_EDGE_A0, MODE_EDGE_A1,
      MODE_EDGE_B0, MODE_EDGE_B1: chan_next = count_next;
      default:       chan_next = field;
    endcase
  end

  // Counter clears on reset; the channel output is registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg      <= COUNT_RESET;
      active_channel <= COUNT_RESET;
    end else begin
      count_reg      <= count_next;
      active_channel <= chan_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.
  reg_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_REG) |=> (active_channel == $past(field)))
    else $error("register mode channel mismatch");
  pin_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_B1A1) |=>
      (active_channel == {2'b00, $past(pin_sync_reg[PIN_B1]),
                          $past(pin_sync_reg[PIN_A1])}))
    else $error("pin pair channel mismatch");
  b_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_B1B0) |=>
      (active_channel == {2'b00, $past(pin_sync_reg[PIN_B1]),
                          $past(pin_sync_reg[PIN_B0])}))
    else $error("B pin pair channel mismatch");
  full_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_B1B0A1A0) |=> (active_channel == $past(pin_sync_reg)))
    else $error("four pin channel mismatch");
  edge_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_EDGE_A0 && pin_rise[PIN_A0] && count_reg < field) |=>
      (count_reg == $past(count_reg) + 4'h1))
    else $error("counter did not step");
  wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
    (edge_hit && count_reg >= field) |=> (count_reg == COUNT_RESET))
    else $error("counter did not wrap");
  hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !edge_hit |=> $stable(count_reg))
    else $error("counter moved without edge");
  high_chan_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_REG && field == 4'hF) [*2] |-> (active_channel == 4'hF))
    else $error("channel 15 not selected");
  unlisted_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == 4'h7) |=> (active_channel == $past(field)))
    else $error("unlisted mode not field");
  b0a0_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_B0A0) |=>
      (active_channel == {2'b00, $past(pin_sync_reg[PIN_B0]),
                          $past(pin_sync_reg[PIN_A0])}))
    else $error("B0 A0 pair channel mismatch");
  a_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_A1A0) |=>
      (active_channel == {2'b00, $past(pin_sync_reg[PIN_A1]),
                          $past(pin_sync_reg[PIN_A0])}))
    else $error("A pin pair channel mismatch");
  mixed_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
    (mode == MODE_B1A1B0A0) |=>
      (active_channel == {$past(pin_sync_reg[PIN_B1]),
                          $past(pin_sync_reg[PIN_A1]),
                          $past(pin_sync_reg[PIN_B0]),
                          $past(pin_sync_reg[PIN_A0])}))
    else $error("interleaved pin channel mismatch");
  // A stored write must show in the register on the next cycle.
  ctrl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && hit && pstrb[0]) |=>
      (ctrl_reg == $past(pwdata[7:0])))
    else $error("register write not stored");

endmodule

// file: hdl/osc_sel_pkg.sv
// Constants for the oscillator channel selection block.
package osc_sel_pkg;
  // Register map: printed offset is a byte address (multiple of four).
  localparam logic [11:0] CTRL_ADDR      = 12'h354;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam int          MODE_MSB       = 7;
  localparam int          MODE_LSB       = 4;
  localparam int          CHAN_MSB       = 3;
  localparam int          CHAN_LSB       = 0;
  localparam logic [3:0]  COUNT_RESET    = 4'h0;
  // Select-mode codes.
  localparam logic [3:0]  MODE_REG       = 4'h0;
  localparam logic [3:0]  MODE_B0A0      = 4'h1;
  localparam logic [3:0]  MODE_B1A1      = 4'h2;
  localparam logic [3:0]  MODE_A1A0      = 4'h3;
  localparam logic [3:0]  MODE_B1B0      = 4'h4;
  localparam logic [3:0]  MODE_B1A1B0A0  = 4'h5;
  localparam logic [3:0]  MODE_B1B0A1A0  = 4'h6;
  localparam logic [3:0]  MODE_EDGE_A0   = 4'h8;
  localparam logic [3:0]  MODE_EDGE_A1   = 4'h9;
  localparam logic [3:0]  MODE_EDGE_B0   = 4'hA;
  localparam logic [3:0]  MODE_EDGE_B1   = 4'hB;
  // Pin vector order inside the block: {b1, b0, a1, a0}.
  localparam int          PIN_A0         = 0;
  localparam int          PIN_A1         = 1;
  localparam int          PIN_B0         = 2;
  localparam int          PIN_B1         = 3;
endpackage

// file: bench/pin_ctrl_model.sv
// Model of the external controller that drives the channel-select pins.
`timescale 1ns/10ps
module pin_ctrl_model (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requested pin levels, order {b1, b0, a1, a0}.
  input  wire logic [3:0] want,
  // Pins toward the device.
  output logic      [3:0] pins
);
  // Pins move just after an edge, as a clocked controller would drive them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pins <= 4'h0;
    else
      pins <= want;
  end
endmodule

// file: bench/nco_channel_select_tb.sv
// Self-checking bench for the oscillator channel selection block.
`timescale 1ns/10ps
module nco_channel_select_tb;
  import osc_sel_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  want, pins, active_channel, cnt, strb;
  int          n_mismatch, checks_done;

  nco_channel_select dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_pin_a_bit0(pins[PIN_A0]), .select_pin_a_bit1(pins[PIN_A1]),
    .select_pin_b_bit0(pins[PIN_B0]), .select_pin_b_bit1(pins[PIN_B1]),
    .active_channel(active_channel));
  pin_ctrl_model ctrl (.pclk(pclk), .presetn(presetn), .want(want),
    .pins(pins));

  // Free-running bus clock, 50 ns period.
  always #25 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Compares one value; an unknown bit matches only an unknown bit in the expected value.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  task chan(input logic [3:0] exp);
    chk({28'h0, active_channel}, {28'h0, exp});
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      tally_and_finish;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Writes mode and field, then lets the new selection settle.
  task wr_ctrl(input logic [3:0] m, input logic [3:0] f);
    xfer(1'b1, CTRL_ADDR, {24'h0, m, f});
    repeat (4) @(posedge pclk);
  endtask

  // One rising and falling edge on one pin, long enough to pass the sync.
  task pulse(input int i);
    want[i] <= 1'b1;
    repeat (4) @(posedge pclk);
    want[i] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask

  // Reference selection, built from pin order {b1, b0, a1, a0}.
  function automatic logic [3:0] exp_ch(logic [3:0] m, f, p, c);
    case (m)
      4'h1: exp_ch = {2'h0, p[2], p[0]};
      4'h2: exp_ch = {2'h0, p[3], p[1]};
      4'h3: exp_ch = {2'h0, p[1], p[0]};
      4'h4: exp_ch = {2'h0, p[3], p[2]};
      4'h5: exp_ch = {p[3], p[1], p[2], p[0]};
      4'h6: exp_ch = p;
      4'h8, 4'h9, 4'hA, 4'hB: exp_ch = c;
      default: exp_ch = f;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register access, field, pin and edge modes.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 4'h0;
    cnt = 4'h0;
    strb = 4'hF;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, {24'h0, CTRL_RESET});
    chk({31'h0, er}, 32'h0);
    chan(4'h0);
    // An unmapped word answers with an error and stores nothing.
    xfer(1'b1, 12'h358, 32'h0000_00FF);
    chk({31'h0, er}, 32'h1);
    xfer(1'b0, 12'h358, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    xfer(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    for (int f = 0; f < 16; f++) begin
      wr_ctrl(MODE_REG, f[3:0]);
      chan(f[3:0]);
      xfer(1'b0, CTRL_ADDR, 32'h0);
      chk(rd, {28'h0, f[3:0]});
    end
    // A write with the low byte lane off must leave the register alone.
    strb <= 4'h0;
    xfer(1'b1, CTRL_ADDR, 32'h0000_0003);
    strb <= 4'hF;
    xfer(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, 32'h0000_000F);
    // Two pin patterns with every bit differing, through all sixteen modes.
    for (int j = 0; j < 2; j++) begin
      want <= (j == 0) ? 4'h6 : 4'h9;
      for (int m = 0; m < 16; m++) begin
        wr_ctrl(m[3:0], 4'hF);
        chan(exp_ch(m[3:0], 4'hF, want, cnt));
      end
    end
    want <= 4'h0;
    wr_ctrl(MODE_REG, 4'h0);
    // Limit of two forces a wrap; the other pin must not count.
    for (int m = 8; m < 12; m++) begin
      wr_ctrl(m[3:0], 4'h2);
      for (int k = 0; k < 4; k++) begin
        pulse(m - 8);
        cnt = (cnt >= 4'h2) ? 4'h0 : cnt + 4'h1;
        chan(cnt);
      end
      pulse((m - 7) % 4);
      chan(cnt);
    end
    // A reset in mid-run must clear the counter, which now holds one.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    xfer(1'b0, CTRL_ADDR, 32'h0);
    chk(rd, {24'h0, CTRL_RESET});
    wr_ctrl(MODE_EDGE_A0, 4'h2);
    chan(4'h0);
    pulse(PIN_A0);
    chan(4'h1);
    wr_ctrl(MODE_EDGE_A0, 4'h0);
    pulse(PIN_A0);
    chan(4'h0);
    tally_and_finish;
  end
endmodule
